// file: hdl/las_alarm_status.sv
`default_nettype none
module las_alarm_status
	import las_pkg::*;
#(
	parameter int NCH = las_pkg::NUM_CH
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic [NCH-1:0]   line_pulse,
	input  wire logic [NCH-1:0]   pattern_bit,
	input  wire logic [NCH-1:0]   analog_los,
	input  wire logic [NCH-1:0]   receive_lock_loss,
	input  wire logic [NCH-1:0]   transmit_drive_monitor,
	input  wire logic [NCH-1:0]   jitter_enable,
	input  wire logic [NCH*6-1:0] fifo_fill,
	input  wire logic [NCH*6-1:0] fifo_depth,
	input  wire logic             reg_rd,
	input  wire logic             reg_wr,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	output var  logic [7:0]       reg_rdata_reg,
	output var  logic             reg_rvalid_reg
);
	import las_pkg::*;

	logic [NCH-1:0] dlos_w;
	logic [NCH-1:0] los_prev_reg;
	logic [NCH-1:0] los_flag_reg;
	logic [NCH-1:0] fifo_lim_reg;
	logic [NCH-1:0] pat_loss_reg;
	logic [NCH-1:0] los_now;
	logic [PAT_LEN-1:0] prbs_reg [NCH];
	logic [6:0]     pat_cnt_reg [NCH];
	logic [6:0]     pat_err_reg [NCH];
	logic [7:0]     status_w [NCH];

	function automatic int ch_of(input logic [7:0] a, input logic [7:0] b0,
			input logic [7:0] b1, input logic [7:0] b2);
		if (a == b0) begin
			return 0;
		end else if (a == b1) begin
			return 1;
		end else if (a == b2) begin
			return 2;
		end
		return -1;
	endfunction : ch_of

	assign los_now = analog_los | dlos_w;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [5:0] fill;
		logic [5:0] depth;
		logic       pred;
		assign fill  = fifo_fill[c*6 +: 6];
		assign depth = fifo_depth[c*6 +: 6];
		assign pred  = prbs_reg[c][PAT_LEN-1] ^ prbs_reg[c][PAT_LEN-2];

		las_dlos u_dlos (
			.mclk       (mclk),
			.sys_rst    (sys_rst),
			.line_pulse (line_pulse[c]),
			.dlos_reg   (dlos_w[c])
		);

		// Self-synchronising pattern checker, errors counted per window
		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				prbs_reg[c]    <= '0;
				pat_cnt_reg[c] <= 7'h00;
				pat_err_reg[c] <= 7'h00;
				pat_loss_reg[c] <= 1'b0;
			end else begin
				prbs_reg[c] <= {prbs_reg[c][PAT_LEN-2:0], pattern_bit[c]};
				if (pat_cnt_reg[c] == 7'(PAT_WINDOW - 1)) begin
					pat_cnt_reg[c] <= 7'h00;
					pat_err_reg[c] <= 7'h00;
					if (pat_err_reg[c] >= 7'(PAT_LOSS_ERRS)) begin
						pat_loss_reg[c] <= 1'b1;
					end else if (pat_err_reg[c] <= 7'(PAT_LOCK_ERRS)) begin
						pat_loss_reg[c] <= 1'b0;
					end
				end else begin
					pat_cnt_reg[c] <= pat_cnt_reg[c] + 7'h01;
					if (pred != pattern_bit[c] && pat_err_reg[c] != 7'h7f) begin
						pat_err_reg[c] <= pat_err_reg[c] + 7'h01;
					end
				end
			end
		end

		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				fifo_lim_reg[c] <= 1'b0;
			end else begin
				// Widened sum so a nearly full deep FIFO cannot wrap
				fifo_lim_reg[c] <= jitter_enable[c] && (fill <= 6'(FIFO_MARGIN)
					|| {1'b0, fill} + 7'(FIFO_MARGIN) >= {1'b0, depth});
			end
		end

		always_comb begin
			status_w[c]                = STATUS_RESET;
			status_w[c][BIT_DRIVE_MON] = transmit_drive_monitor[c];
			status_w[c][BIT_LOS]       = los_now[c];
			status_w[c][BIT_LOCK_LOSS] = receive_lock_loss[c];
			status_w[c][BIT_FIFO_LIM]  = fifo_lim_reg[c];
			status_w[c][BIT_ALOS]      = analog_los[c];
			status_w[c][BIT_DLOS]      = dlos_w[c];
			status_w[c][BIT_PAT]       = pat_loss_reg[c];
		end
	end

	// Change flags: a new change wins over a read clear
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			los_prev_reg <= '0;
			los_flag_reg <= '0;
		end else begin
			los_prev_reg <= los_now;
			for (int c = 0; c < NCH; c++) begin
				if (los_now[c] != los_prev_reg[c]) begin
					los_flag_reg[c] <= 1'b1;
				end else if (reg_rd && ch_of(reg_addr, ADDR_CHANGE_CH0, ADDR_CHANGE_CH1,
						ADDR_CHANGE_CH2) == c) begin
					los_flag_reg[c] <= 1'b0;
				end
			end
		end
	end

	// Read port; writes are not decoded at all
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_reg  <= STATUS_RESET;
			reg_rvalid_reg <= 1'b0;
		end else begin
			reg_rvalid_reg <= reg_rd;
			if (!reg_rd) begin
				reg_rdata_reg <= STATUS_RESET;
			end else if (ch_of(reg_addr, ADDR_STATUS_CH0, ADDR_STATUS_CH1,
					ADDR_STATUS_CH2) >= 0) begin
				reg_rdata_reg <= status_w[ch_of(reg_addr, ADDR_STATUS_CH0,
					ADDR_STATUS_CH1, ADDR_STATUS_CH2)];
			end else if (ch_of(reg_addr, ADDR_CHANGE_CH0, ADDR_CHANGE_CH1,
					ADDR_CHANGE_CH2) >= 0) begin
				reg_rdata_reg <= STATUS_RESET;
				reg_rdata_reg[FLAG_LOS] <= los_flag_reg[ch_of(reg_addr, ADDR_CHANGE_CH0,
					ADDR_CHANGE_CH1, ADDR_CHANGE_CH2)];
			end else begin
				reg_rdata_reg <= STATUS_RESET;
			end
		end
	end

	a_bit7_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		!reg_rdata_reg[7])
		else $error("bit 7 of status read as one");
	a_los_or: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH0)
		|=> reg_rdata_reg[BIT_LOS] == $past(analog_los[0] | dlos_w[0]))
		else $error("combined loss of signal not OR of detectors");
	a_pat_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH0)
		|=> reg_rdata_reg[BIT_PAT] == $past(pat_loss_reg[0]))
		else $error("pattern loss bit mismatch");
	a_dlos_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH1)
		|=> reg_rdata_reg[BIT_DLOS] == $past(dlos_w[1]))
		else $error("digital loss bit mismatch");
	a_los_pos: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH2)
		|=> reg_rdata_reg[BIT_LOS] == $past(los_now[2]))
		else $error("combined loss bit not in bit 1");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == 8'h04) |=> reg_rdata_reg == STATUS_RESET)
		else $error("unmapped address returned data");
	a_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(los_now[0]) |=> los_flag_reg[0])
		else $error("change flag not set");
	a_fifo_lim_off: assert property (@(posedge mclk) disable iff (sys_rst)
		!jitter_enable[0] |=> !fifo_lim_reg[0])
		else $error("fifo limit set with attenuator disabled");
	a_pat_slow: assert property (@(posedge mclk) disable iff (sys_rst)
		pat_cnt_reg[0] != 7'(PAT_WINDOW - 1) |=> $stable(pat_loss_reg[0]))
		else $error("pattern lock changed outside window end");
	a_flag_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_CHANGE_CH0 && !$changed(los_now[0]))
		|=> !los_flag_reg[0])
		else $error("change flag not cleared by read");

	// Read port timing and field placement
	a_rvalid_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd |=> reg_rvalid_reg)
		else $error("read not answered one cycle later");
	a_idle_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		!reg_rd |=> (!reg_rvalid_reg && reg_rdata_reg == STATUS_RESET))
		else $error("read port not idle without read");
	a_drive_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH0)
		|=> reg_rdata_reg[BIT_DRIVE_MON] == $past(transmit_drive_monitor[0]))
		else $error("drive monitor bit mismatch");
	a_lock_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH1)
		|=> reg_rdata_reg[BIT_LOCK_LOSS] == $past(receive_lock_loss[1]))
		else $error("receive lock loss bit mismatch");
	a_fifo_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH2)
		|=> reg_rdata_reg[BIT_FIFO_LIM] == $past(fifo_lim_reg[2]))
		else $error("fifo limit bit mismatch");
	a_alos_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_STATUS_CH2)
		|=> reg_rdata_reg[BIT_ALOS] == $past(analog_los[2]))
		else $error("analog loss bit mismatch");

	// Change flag holding and read back, pattern lock decisions at window end
	a_flag_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(los_flag_reg[1] && !(reg_rd && reg_addr == ADDR_CHANGE_CH1)) |=> los_flag_reg[1])
		else $error("change flag lost without read");
	a_flag_read: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == ADDR_CHANGE_CH1)
		|=> reg_rdata_reg[FLAG_LOS] == $past(los_flag_reg[1]))
		else $error("change flag read back mismatch");
	a_pat_lose: assert property (@(posedge mclk) disable iff (sys_rst)
		(pat_cnt_reg[0] == 7'(PAT_WINDOW - 1) && pat_err_reg[0] >= 7'(PAT_LOSS_ERRS))
		|=> pat_loss_reg[0])
		else $error("pattern lock kept despite many errors");
	a_pat_regain: assert property (@(posedge mclk) disable iff (sys_rst)
		(pat_cnt_reg[0] == 7'(PAT_WINDOW - 1) && pat_err_reg[0] <= 7'(PAT_LOCK_ERRS))
		|=> !pat_loss_reg[0])
		else $error("pattern lock not regained on clean window");

	c_los_rise: cover property (@(posedge mclk) disable iff (sys_rst) $rose(dlos_w[0]));
	c_pat_lock: cover property (@(posedge mclk) disable iff (sys_rst) $fell(pat_loss_reg[0]));
	c_pat_loss: cover property (@(posedge mclk) disable iff (sys_rst) $rose(pat_loss_reg[0]));
	c_fifo_lim_set: cover property (@(posedge mclk) disable iff (sys_rst) $rose(fifo_lim_reg[1]));
	c_flag_rd: cover property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && reg_addr == ADDR_CHANGE_CH2 && los_flag_reg[2]);
endmodule : las_alarm_status
`default_nettype wire

// file: hdl/las_dlos.sv
`default_nettype none
module las_dlos
	import las_pkg::*;
#(
	parameter int ZERO_RUN = LOS_ZERO_RUN,
	parameter int WIN      = DENSITY_WINDOW,
	parameter int MIN_ONES = DENSITY_MIN
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic line_pulse,
	output var  logic dlos_reg
);
	logic [7:0] zero_run_reg;
	logic [7:0] win_cnt_reg;
	logic [7:0] ones_cnt_reg;

	// Count consecutive bit periods without a pulse
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			zero_run_reg <= 8'h00;
		end else if (line_pulse) begin
			zero_run_reg <= 8'h00;
		end else if (zero_run_reg < 8'(ZERO_RUN)) begin
			zero_run_reg <= zero_run_reg + 8'h01;
		end
	end

	// Density measured over fixed windows of bit periods
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			win_cnt_reg  <= 8'h00;
			ones_cnt_reg <= 8'h00;
		end else if (win_cnt_reg == 8'(WIN - 1)) begin
			win_cnt_reg  <= 8'h00;
			ones_cnt_reg <= 8'h00;
		end else begin
			win_cnt_reg  <= win_cnt_reg + 8'h01;
			ones_cnt_reg <= ones_cnt_reg + {7'h00, line_pulse};
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dlos_reg <= 1'b0;
		end else if (!line_pulse && zero_run_reg == 8'(ZERO_RUN - 1)) begin
			dlos_reg <= 1'b1;
		end else if (win_cnt_reg == 8'(WIN - 1)
				&& ones_cnt_reg + {7'h00, line_pulse} >= 8'(MIN_ONES)) begin
			dlos_reg <= 1'b0;
		end
	end

	a_dlos_declare: assert property (@(posedge mclk) disable iff (sys_rst)
		(!line_pulse && zero_run_reg == 8'(ZERO_RUN - 1)) |=> dlos_reg)
		else $error("digital loss of signal not declared after zero run");
	a_dlos_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(dlos_reg && win_cnt_reg != 8'(WIN - 1)) |=> dlos_reg)
		else $error("digital loss of signal cleared outside window end");
endmodule : las_dlos
`default_nettype wire

// file: hdl/las_pkg.sv
// Notes on behaviour
// - Bit 6 reads 1 while pattern receiver has lost lock, 0 while locked.
// - Pattern receiver declares lock loss after many bit errors in incoming data.
// - Lock loss clears once the pattern is found with few or no errors.
// - Digital loss of signal declared after 160 consecutive bit periods without pulses.
// - Digital loss of signal clears once pulse density reaches one third.
// - Bit 5 reads 1 while the digital detector declares loss of signal.
// - Combined loss of signal is analog OR digital declaration.
// - Combined loss of signal appears in bit 1.
// - Status sits at 0x03, 0x0b and 0x13 for channels 0, 1, 2.
// - FIFO limit bit set within two bit periods of overflow or underrun, when enabled.
// - Each combined loss-of-signal change sets a flag cleared by reading the flag register.
`default_nettype none
package las_pkg;
	localparam int NUM_CH = 3;
	localparam logic [7:0] ADDR_STATUS_CH0 = 8'h03;
	localparam logic [7:0] ADDR_STATUS_CH1 = 8'h0b;
	localparam logic [7:0] ADDR_STATUS_CH2 = 8'h13;
	localparam logic [7:0] ADDR_CHANGE_CH0 = 8'h02;
	localparam logic [7:0] ADDR_CHANGE_CH1 = 8'h0a;
	localparam logic [7:0] ADDR_CHANGE_CH2 = 8'h12;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int BIT_DRIVE_MON = 0;
	localparam int BIT_LOS = 1;
	localparam int BIT_LOCK_LOSS = 2;
	localparam int BIT_FIFO_LIM = 3;
	localparam int BIT_ALOS = 4;
	localparam int BIT_DLOS = 5;
	localparam int BIT_PAT = 6;
	localparam int FLAG_LOS = 1;
	localparam int LOS_ZERO_RUN = 160;
	localparam int DENSITY_WINDOW = 24;
	localparam int DENSITY_MIN = 8;
	localparam int FIFO_MARGIN = 2;
	localparam int PAT_WINDOW = 64;
	localparam int PAT_LOSS_ERRS = 16;
	localparam int PAT_LOCK_ERRS = 1;
	localparam int PAT_LEN = 15;
endpackage : las_pkg
`default_nettype wire

// file: test/las_line_model.sv
`default_nettype none
module las_line_model (
	input  wire logic [7:0] pulse_gap,
	input  wire logic       pat_invert,
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	output var  logic [2:0] line_pulse,
	output var  logic [2:0] pattern_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] prbs_reg;
	logic [7:0]  gap_cnt_reg;
	logic        fb;
	assign fb = prbs_reg[14] ^ prbs_reg[13];
	// Generator stream looped back to the receiver, optionally inverted
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			prbs_reg <= 15'h0001;
		else
			prbs_reg <= {prbs_reg[13:0], fb};
	end
	// One pulse every pulse_gap bit periods, none when zero
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			gap_cnt_reg <= 8'h00;
		else if (pulse_gap == 8'h00 || gap_cnt_reg >= pulse_gap - 8'h01)
			gap_cnt_reg <= 8'h00;
		else
			gap_cnt_reg <= gap_cnt_reg + 8'h01;
	end
	assign line_pulse  = {3{pulse_gap != 8'h00 && gap_cnt_reg == 8'h00}};
	assign pattern_bit = {3{fb ^ pat_invert}};
endmodule : las_line_model
`default_nettype wire

// file: test/line_alarm_status_test.sv
`default_nettype none
module line_alarm_status_test;
	import las_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [2:0]  alos = 3'h0, lock_loss = 3'h0, tdm = 3'h0, jit = 3'h0, pulse, pbit;
	logic [17:0] fill = 18'h00000, depth = 18'h00000;
	logic        rd = 1'b0, wr = 1'b0, inv = 1'b0, rvalid;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, gap = 8'h01, rdata;
	int          n_fail = 0, checked = 0, cycles = 0;

	always #50 mclk = ~mclk;

	las_line_model i_las_line_model (.mclk(mclk), .sys_rst(sys_rst), .pulse_gap(gap),
		.pat_invert(inv), .line_pulse(pulse), .pattern_bit(pbit));
	las_alarm_status i_las_alarm_status (.mclk(mclk), .sys_rst(sys_rst), .line_pulse(pulse),
		.pattern_bit(pbit), .analog_los(alos), .receive_lock_loss(lock_loss),
		.transmit_drive_monitor(tdm), .jitter_enable(jit), .fifo_fill(fill),
		.fifo_depth(depth), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata_reg(rdata), .reg_rvalid_reg(rvalid));

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
		rd = 1'b1;
		addr = a;
		cyc(1);
		rd = 1'b0;
		chk("rvalid", 8'h01, {7'h00, rvalid});
		chk("rdata", exp & mask, rdata & mask);
		cyc(1);
		chk("rdata idle", 8'h00, rdata);
	endtask : rd_chk

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task automatic t_pass();
		tdm = 3'b001;
		lock_loss = 3'b010;
		alos = 3'b100;
		cyc(2);
		rd_chk(ADDR_STATUS_CH0, 8'hbf, 8'h01);
		rd_chk(ADDR_STATUS_CH1, 8'hbf, 8'h04);
		rd_chk(ADDR_STATUS_CH2, 8'hbf, 8'h12);
		wr = 1'b1;
		addr = ADDR_STATUS_CH0;
		wdata = 8'hff;
		cyc(1);
		wr = 1'b0;
		rd_chk(ADDR_STATUS_CH0, 8'hbf, 8'h01);
		rd_chk(8'h04, 8'hff, 8'h00);
		rd_chk(ADDR_CHANGE_CH2, 8'hff, 8'h02);
		rd_chk(ADDR_CHANGE_CH2, 8'hff, 8'h00);
		{tdm, lock_loss, alos} = 9'h000;
		cyc(2);
		rd_chk(ADDR_STATUS_CH2, 8'hbf, 8'h00);
	endtask : t_pass

	task automatic t_dlos();
		gap = 8'h00;
		cyc(158);
		rd_chk(ADDR_STATUS_CH1, 8'h22, 8'h00);
		cyc(2);
		rd_chk(ADDR_STATUS_CH1, 8'h22, 8'h22);
		rd_chk(ADDR_CHANGE_CH1, 8'h02, 8'h02);
		rd_chk(ADDR_CHANGE_CH0, 8'h02, 8'h02);
		gap = 8'h04;
		cyc(48);
		rd_chk(ADDR_STATUS_CH1, 8'h22, 8'h22);
		gap = 8'h03;
		cyc(72);
		rd_chk(ADDR_STATUS_CH1, 8'h22, 8'h00);
	endtask : t_dlos

	task automatic t_pat();
		gap = 8'h01;
		cyc(300);
		rd_chk(ADDR_STATUS_CH0, 8'h40, 8'h00);
		inv = 1'b1;
		cyc(200);
		rd_chk(ADDR_STATUS_CH0, 8'h40, 8'h40);
		inv = 1'b0;
		cyc(200);
		rd_chk(ADDR_STATUS_CH0, 8'h40, 8'h00);
	endtask : t_pat

	task automatic t_fifo();
		logic [5:0] f [4] = '{6'h02, 6'h03, 6'h1e, 6'h1d};
		depth = {3{6'h20}};
		jit = 3'h7;
		for (int i = 0; i < 4; i++) begin
			fill = {3{f[i]}};
			cyc(2);
			rd_chk(ADDR_STATUS_CH2, 8'h08, {4'h0, ~i[0], 3'h0});
		end
		jit = 3'h0;
		fill = {3{6'h02}};
		cyc(2);
		rd_chk(ADDR_STATUS_CH2, 8'h08, 8'h00);
	endtask : t_fifo

	always @(posedge mclk) begin
		cycles++;
		if (cycles > 5000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		cyc(5);
		chk("rvalid in reset", 8'h00, {7'h00, rvalid});
		sys_rst = 1'b0;
		rd_chk(ADDR_STATUS_CH0, 8'hff, STATUS_RESET);
		t_pass();
		t_dlos();
		t_pat();
		t_fifo();
		finish_test();
	end
endmodule : line_alarm_status_test
`default_nettype wire
